// >>> shared/ocm_pkg.sv
// Purpose: shared constants and types for the output cell array
// Assumes: one 250 MHz clock, 8-bit host data, 137 product terms
// Notes: host offsets are relative to the configuration io space
package ocm_pkg;

  // ----------------------------------------------------------------
  // array sizes
  // ----------------------------------------------------------------
  localparam int NPT = 137;  // product terms in the and array
  localparam int NEXT = 57;  // array inputs other than cell feedback
  localparam int NCELL = 8;  // cells per group
  localparam int NIN = NEXT + 2 * NCELL;
  localparam int NCS = 3;  // external chip selects
  localparam int PTSEL_W = 8;  // width of a term index

  // ----------------------------------------------------------------
  // product term ownership
  // ----------------------------------------------------------------
  localparam int NAT_AB = 3;
  localparam int NAT_BC = 4;
  localparam int BOR_AB = 6;
  localparam int BOR_BC_LO = 5;
  localparam int BOR_BC_HI = 6;
  localparam int BASE_AB = 0;
  localparam int BASE_BC = BASE_AB + NAT_AB * NCELL;
  localparam logic [3:0] NAT_MSK_AB = 4'h7;
  localparam logic [3:0] NAT_MSK_BC = 4'hF;

  // ----------------------------------------------------------------
  // host offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CELL_AB = 8'h20;
  localparam logic [7:0] OFS_CELL_BC = 8'h21;
  localparam logic [7:0] OFS_MASK_AB = 8'h22;
  localparam logic [7:0] OFS_MASK_BC = 8'h23;
  localparam logic [7:0] OFS_IN_A = 8'h0A;
  localparam logic [7:0] OFS_IN_B = 8'h0B;
  localparam logic [7:0] OFS_IN_C = 8'h18;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;  // strobes idle high

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OCM_FF_D, OCM_FF_T, OCM_FF_JK, OCM_FF_SR} ocm_ff_t;

  typedef struct packed {
    ocm_ff_t kind;
    logic clk_ext;  // clock from the external clock pin
    logic use_reg;  // registered result, else combinational
    logic invert;  // polarity of the summed terms
    logic to_pin;  // 0: internal node only
    logic pin_hi;  // 0: port a or b, 1: port b or c
    logic oe_eq;  // an output enable equation exists
    logic [3:0] lend_en;
    logic [3:0] lend_right;
    logic [PTSEL_W-1:0] sel_clk;
    logic [PTSEL_W-1:0] sel_pre;
    logic [PTSEL_W-1:0] sel_clr0;
    logic [PTSEL_W-1:0] sel_clr1;
    logic [PTSEL_W-1:0] sel_k;
    logic [PTSEL_W-1:0] sel_oe;
  } ocm_cfg_t;

  typedef struct packed {
    logic clk;
    logic pre;
    logic clr;
    logic k;
    logic oe;
  } ocm_pt_t;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic sel;  // configuration io space selected
    logic [7:0] addr;
    logic [7:0] din;
  } ocm_host_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } ocm_port_t;

endpackage : ocm_pkg

// >>> src/ocm_array.sv
// Purpose: complex logic section output cell array with its and array
// Assumes: fuse configuration is static; host address and data are
//   stable while a host strobe is seen active
// Notes: host strobes and the external clock pin pass three flops
`timescale 1ns/100ps
module ocm_array
  import ocm_pkg::*;
#(
  parameter logic [7:0] P_CELL_AB = OFS_CELL_AB,
  parameter logic [7:0] P_CELL_BC = OFS_CELL_BC,
  parameter logic [7:0] P_MASK_AB = OFS_MASK_AB,
  parameter logic [7:0] P_MASK_BC = OFS_MASK_BC,
  parameter logic [7:0] P_IN_A = OFS_IN_A,
  parameter logic [7:0] P_IN_B = OFS_IN_B,
  parameter logic [7:0] P_IN_C = OFS_IN_C
) (
  input wire logic MCLK,  // 250 MHz clock
  input wire logic RST_N,  // async reset, active low
  input wire ocm_host_t HOST,  // host strobes, address, data
  output logic [7:0] DOUT,  // host read data
  output logic DOUT_OE,  // host read data drive enable
  input wire logic LOAD_LEVEL,  // 1: load while write active
  input wire logic EXT_CLK,  // external clock pin
  input wire logic [NEXT-1:0] ARR_IN,  // other and array inputs
  input wire logic [NPT-1:0][NIN-1:0] ARR_TRUE,  // true literal fuses
  input wire logic [NPT-1:0][NIN-1:0] ARR_COMP,  // complement fuses
  input wire ocm_cfg_t [2*NCELL-1:0] CELL_CFG,  // cell configuration
  input wire logic [NCS-1:0][PTSEL_W-1:0] CS_SEL,  // chip select terms
  input wire ocm_port_t DIR,  // port direction bits
  input wire ocm_port_t IN_CELLS,  // input cell values
  output ocm_port_t PIN_OUT,  // port pin data
  output ocm_port_t PIN_OE,  // port pin drive enable
  output logic [NCS-1:0] CS_OUT,  // port d chip selects
  output logic [2*NCELL-1:0] FEEDBACK  // cell results to the array
);

  // ----------------------------------------------------------------
  // term selection helper
  // ----------------------------------------------------------------
  function automatic logic pick(input logic [NPT-1:0] t,
                                input logic [PTSEL_W-1:0] idx);
    return (int'(idx) < NPT) ? t[idx] : 1'b0;
  endfunction : pick

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] wr_s_r;
  logic [2:0] rd_s_r;
  logic [2:0] ck_s_r;
  logic wr_lvl_r;
  logic rd_lvl_r;
  logic ck_lvl_r;
  logic wr_lvl_nxt;
  logic rd_lvl_nxt;
  logic ck_lvl_nxt;

  // a change counts once the second and third flops agree
  assign wr_lvl_nxt = (wr_s_r[1] == wr_s_r[2]) ? ~wr_s_r[2] : wr_lvl_r;
  assign rd_lvl_nxt = (rd_s_r[1] == rd_s_r[2]) ? ~rd_s_r[2] : rd_lvl_r;
  assign ck_lvl_nxt = (ck_s_r[1] == ck_s_r[2]) ? ck_s_r[2] : ck_lvl_r;

  // shift chains and filtered levels
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_s_r <= SYNC_RST;
      rd_s_r <= SYNC_RST;
      ck_s_r <= '0;
      wr_lvl_r <= 1'b0;
      rd_lvl_r <= 1'b0;
      ck_lvl_r <= 1'b0;
    end else begin
      wr_s_r <= {wr_s_r[1:0], HOST.wr_n};
      rd_s_r <= {rd_s_r[1:0], HOST.rd_n};
      ck_s_r <= {ck_s_r[1:0], EXT_CLK};
      wr_lvl_r <= wr_lvl_nxt;
      rd_lvl_r <= rd_lvl_nxt;
      ck_lvl_r <= ck_lvl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // host write capture and decode
  // ----------------------------------------------------------------
  logic [7:0] wdat_r;
  logic [7:0] wadr_r;
  logic wsel_r;
  logic wr_trail;
  logic ext_rise;
  logic load_cyc;
  logic hit_cab;
  logic hit_cbc;
  logic hit_mab;
  logic hit_mbc;

  // data and address follow the bus while write is active
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wdat_r <= BYTE_RST;
      wadr_r <= BYTE_RST;
      wsel_r <= 1'b0;
    end else if (wr_lvl_nxt) begin
      wdat_r <= HOST.din;
      wadr_r <= HOST.addr;
      wsel_r <= HOST.sel;
    end
  end

  assign wr_trail = wr_lvl_r & ~wr_lvl_nxt;
  assign ext_rise = ck_lvl_nxt & ~ck_lvl_r;
  assign load_cyc = LOAD_LEVEL ? (wr_lvl_r & wr_lvl_nxt) : wr_trail;
  assign hit_cab = wsel_r & (wadr_r == P_CELL_AB);
  assign hit_cbc = wsel_r & (wadr_r == P_CELL_BC);
  assign hit_mab = wsel_r & (wadr_r == P_MASK_AB) & wr_trail;
  assign hit_mbc = wsel_r & (wadr_r == P_MASK_BC) & wr_trail;

  // ----------------------------------------------------------------
  // write masks
  // ----------------------------------------------------------------
  logic [7:0] mask_ab_r;
  logic [7:0] mask_bc_r;
  logic [2*NCELL-1:0] ld;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_ab_r <= MASK_RST;
      mask_bc_r <= MASK_RST;
    end else begin
      if (hit_mab) mask_ab_r <= wdat_r;
      if (hit_mbc) mask_bc_r <= wdat_r;
    end
  end

  // data bit n to cell n
  assign ld = {{NCELL{load_cyc & hit_cbc}} & ~mask_bc_r,
               {NCELL{load_cyc & hit_cab}} & ~mask_ab_r};

  // ----------------------------------------------------------------
  // and array
  // ----------------------------------------------------------------
  logic [NIN-1:0] arr_in;
  logic [NPT-1:0] pt;
  logic [2*NCELL-1:0] res;
  logic [2*NCELL-1:0] q;

  assign arr_in = {res, ARR_IN};

  generate
    for (genvar j = 0; j < NPT; j++) begin : g_pt
      assign pt[j] = (|(ARR_TRUE[j] | ARR_COMP[j])) &
                     (&(~ARR_TRUE[j] | arr_in)) &
                     (&(~ARR_COMP[j] | ~arr_in));
    end
  endgenerate

  // ----------------------------------------------------------------
  // cells with term lending
  // ----------------------------------------------------------------
  logic [2*NCELL-1:0][3:0] nat;
  logic [2*NCELL-1:0][3:0] lend_l;
  logic [2*NCELL-1:0][3:0] lend_r;
  logic [2*NCELL-1:0] cell_oe;

  generate
    for (genvar i = 0; i < 2 * NCELL; i++) begin : g_cell
      localparam int G = i / NCELL;
      localparam int N = i % NCELL;
      localparam int BASE = (G == 0) ? BASE_AB + NAT_AB * N : BASE_BC + NAT_BC * N;
      localparam int MAXB = (G == 0) ? BOR_AB : ((N < 4) ? BOR_BC_LO : BOR_BC_HI);
      localparam logic [3:0] MSK = (G == 0) ? NAT_MSK_AB : NAT_MSK_BC;
      logic [3:0] own;
      logic [3:0] from_r;
      logic [3:0] from_l;
      ocm_pt_t pts;

      assign nat[i] = pt[BASE+:4] & MSK;
      assign lend_l[i] = (N > 0) ? (nat[i] & CELL_CFG[i].lend_en & ~CELL_CFG[i].lend_right)
                                 : 4'h0;
      assign lend_r[i] = (N < NCELL - 1)
                         ? (nat[i] & CELL_CFG[i].lend_en & CELL_CFG[i].lend_right) : 4'h0;
      assign own = nat[i] & ~(lend_l[i] | lend_r[i]);
      if (N < NCELL - 1) begin : g_from_r
        assign from_r = lend_l[i+1];
      end else begin : g_no_r
        assign from_r = 4'h0;
      end
      if (N > 0) begin : g_from_l
        assign from_l = lend_r[i-1];
      end else begin : g_no_l
        assign from_l = 4'h0;
      end

      assign pts.clk = pick(pt, CELL_CFG[i].sel_clk);
      assign pts.pre = pick(pt, CELL_CFG[i].sel_pre);
      assign pts.clr = pick(pt, CELL_CFG[i].sel_clr0) | pick(pt, CELL_CFG[i].sel_clr1);
      assign pts.k = pick(pt, CELL_CFG[i].sel_k);
      assign pts.oe = pick(pt, CELL_CFG[i].sel_oe);

      ocm_cell #(
        .MAXB(MAXB)
      ) u_cell (
        .clk(MCLK),
        .rst_n(RST_N),
        .cfg(CELL_CFG[i]),
        .own(own),
        .borrow({from_r, from_l}),
        .pts(pts),
        .ext_rise(ext_rise),
        .ld(ld[i]),
        .ld_bit(wdat_r[N]),
        .q(q[i]),
        .res(res[i])
      );

      assign cell_oe[i] = CELL_CFG[i].to_pin &
        (~CELL_CFG[i].oe_eq | pts.oe |
         ((G == 0) ? (CELL_CFG[i].pin_hi ? DIR.b[N] : DIR.a[N])
                   : (CELL_CFG[i].pin_hi ? DIR.c[N] : DIR.b[N])));
    end
  endgenerate

  assign FEEDBACK = res;

  // ----------------------------------------------------------------
  // port pin routing
  // ----------------------------------------------------------------
  logic [7:0] sel_a;
  logic [7:0] sel_ab_b;
  logic [7:0] sel_bc_b;
  logic [7:0] sel_c;
  ocm_port_t pin_nxt;
  ocm_port_t oe_nxt;
  logic [NCS-1:0] cs_nxt;

  // same bit index on each port
  always_comb begin
    for (int n = 0; n < NCELL; n++) begin
      sel_a[n] = ~CELL_CFG[n].pin_hi;
      sel_ab_b[n] = CELL_CFG[n].pin_hi;
      sel_bc_b[n] = ~CELL_CFG[NCELL+n].pin_hi;
      sel_c[n] = CELL_CFG[NCELL+n].pin_hi;
    end
  end

  assign pin_nxt.a = res[7:0] & sel_a;
  assign pin_nxt.b = (res[7:0] & sel_ab_b) | (res[15:8] & sel_bc_b);
  assign pin_nxt.c = res[15:8] & sel_c;
  assign oe_nxt.a = cell_oe[7:0] & sel_a;
  assign oe_nxt.b = (cell_oe[7:0] & sel_ab_b) | (cell_oe[15:8] & sel_bc_b);
  assign oe_nxt.c = cell_oe[15:8] & sel_c;

  always_comb begin
    for (int c = 0; c < NCS; c++) begin
      cs_nxt[c] = pick(pt, CS_SEL[c]);
    end
  end

  // registered pin outputs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PIN_OUT <= '0;
      PIN_OE <= '0;
      CS_OUT <= '0;
    end else begin
      PIN_OUT <= pin_nxt;
      PIN_OE <= oe_nxt;
      CS_OUT <= cs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // host read
  // ----------------------------------------------------------------
  logic rd_hit;
  logic [7:0] rd_data;

  // read cells over the data bus
  always_comb begin
    rd_hit = HOST.sel & rd_lvl_r;
    rd_data = BYTE_RST;
    if (HOST.addr == P_CELL_AB) rd_data = q[7:0];
    else if (HOST.addr == P_CELL_BC) rd_data = q[15:8];
    else if (HOST.addr == P_MASK_AB) rd_data = mask_ab_r;
    else if (HOST.addr == P_MASK_BC) rd_data = mask_bc_r;
    else if (HOST.addr == P_IN_A) rd_data = IN_CELLS.a;
    else if (HOST.addr == P_IN_B) rd_data = IN_CELLS.b;
    else if (HOST.addr == P_IN_C) rd_data = IN_CELLS.c;
    else rd_hit = 1'b0;
  end

  // read data register, idle and unmapped give zero, undriven
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DOUT <= BYTE_RST;
      DOUT_OE <= 1'b0;
    end else begin
      DOUT <= rd_hit ? rd_data : BYTE_RST;
      DOUT_OE <= rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mask_reset: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !$past(RST_N) |-> mask_ab_r == MASK_RST && mask_bc_r == MASK_RST)
    else $error("mask not zero after reset");
  a_unmasked_load: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    load_cyc && hit_cab |=> ((q[7:0] ^ $past(wdat_r)) & ~$past(mask_ab_r)) == 8'h00)
    else $error("unmasked ab cell did not load");
  a_edge_mode: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !LOAD_LEVEL && wr_lvl_r && wr_lvl_nxt |-> ld == '0)
    else $error("edge mode loaded before trailing edge");
  a_read_back: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    rd_lvl_r && HOST.sel && HOST.addr == P_CELL_BC |=> DOUT_OE && DOUT == $past(q[15:8]))
    else $error("bc cell read back wrong");
  a_pin_follow: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !CELL_CFG[0].pin_hi && $stable(CELL_CFG[0])
    |=> PIN_OUT.a[0] == $past(res[0]))
    else $error("pin a0 does not follow its cell");
  a_oe_default: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    CELL_CFG[8].to_pin && !CELL_CFG[8].oe_eq && !CELL_CFG[8].pin_hi |=> PIN_OE.b[0])
    else $error("pin without oe equation not driven");
  c_edge_load: cover property (@(posedge MCLK) disable iff (!RST_N)
    !LOAD_LEVEL && wr_trail && hit_cab);
  c_level_load: cover property (@(posedge MCLK) disable iff (!RST_N)
    LOAD_LEVEL && load_cyc && hit_cbc [*3]);
  c_masked: cover property (@(posedge MCLK) disable iff (!RST_N)
    load_cyc && hit_cab && mask_ab_r != 8'h00 && mask_ab_r != 8'hFF);

endmodule : ocm_array

// >>> src/ocm_cell.sv
// Purpose: one output cell: term sum, polarity, flip-flop, result mux
// Assumes: terms and load arrive on the same clock
// Notes: clear wins over preset; host load wins over both
`timescale 1ns/100ps
module ocm_cell
  import ocm_pkg::*;
#(
  parameter int MAXB = 6
) (
  input wire logic clk,  // system clock
  input wire logic rst_n,  // async reset, active low
  input wire ocm_cfg_t cfg,  // cell configuration
  input wire logic [3:0] own,  // native terms kept
  input wire logic [7:0] borrow,  // terms lent by neighbours
  input wire ocm_pt_t pts,  // control terms
  input wire logic ext_rise,  // external clock rising
  input wire logic ld,  // host load this cycle
  input wire logic ld_bit,  // host data bit
  output logic q,  // flip-flop state
  output logic res  // selected result
);

  // keep only the first n borrowed terms
  function automatic logic [7:0] keep_first(input logic [7:0] v);
    logic [7:0] r;
    int cnt;
    r = 8'h00;
    cnt = 0;
    for (int b = 0; b < 8; b++) begin
      if (v[b] && cnt < MAXB) begin
        r[b] = 1'b1;
        cnt++;
      end
    end
    return r;
  endfunction : keep_first

  logic sum;
  logic x;
  logic q_r;
  logic q_nxt;
  logic clk_pt_r;
  logic tick;
  logic ff_in;

  assign sum = (|own) | (|keep_first(borrow));
  assign x = sum ^ cfg.invert;
  assign tick = cfg.clk_ext ? ext_rise : (pts.clk & ~clk_pt_r);

  always_comb begin
    unique case (cfg.kind)
      OCM_FF_D: ff_in = x;
      OCM_FF_T: ff_in = q_r ^ x;
      OCM_FF_JK: ff_in = (x & ~q_r) | (~pts.k & q_r);
      OCM_FF_SR: ff_in = x | (~pts.k & q_r);
    endcase
  end

  always_comb begin
    q_nxt = q_r;
    if (ld) begin
      q_nxt = ld_bit;
    end else if (pts.clr) begin
      q_nxt = 1'b0;
    end else if (pts.pre) begin
      q_nxt = 1'b1;
    end else if (tick) begin
      q_nxt = ff_in;
    end
  end

  // state and term clock history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 1'b0;
      clk_pt_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      clk_pt_r <= pts.clk;
    end
  end

  assign q = q_r;
  assign res = cfg.use_reg ? q_r : x;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_load_wins: assert property (
    @(posedge clk) disable iff (!rst_n) ld |=> q_r == $past(ld_bit))
    else $error("host load did not win");
  a_clear_act: assert property (
    @(posedge clk) disable iff (!rst_n) !ld && pts.clr |=> !q_r)
    else $error("clear term did not clear");
  a_d_rise: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ld && !pts.clr && !pts.pre && cfg.kind == OCM_FF_D && tick |=> q_r == $past(x))
    else $error("d capture missed on rising edge");
  a_hold_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ld && !pts.clr && !pts.pre && !tick |=> $stable(q_r))
    else $error("state moved without a clock");
  c_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    cfg.kind == OCM_FF_T && tick && x ##1 $changed(q_r));

endmodule : ocm_cell

// >>> tb/ocm_host_model.sv
// Purpose: host microcontroller model on the config io space strobes
// Assumes: strobes change 1 ns after a rising MCLK edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/100ps
module ocm_host_model
  import ocm_pkg::*;
(
  input wire logic MCLK,  // bus clock
  output ocm_host_t HOST  // strobes, address, data
);
  initial begin
    HOST = '{wr_n: 1'b1, rd_n: 1'b1, sel: 1'b0, addr: 8'h00, din: 8'h00};
  end
  // one strobe held six cycles, qualifiers held past the trailing edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    #1;
    HOST.sel = 1'b1;
    HOST.addr = a;
    HOST.din = d;
    HOST.wr_n = !wr;
    HOST.rd_n = wr;
    repeat (6) @(posedge MCLK);
    #1;
    HOST.wr_n = 1'b1;
    HOST.rd_n = 1'b1;
    repeat (5) @(posedge MCLK);
    #1;
    HOST.sel = 1'b0;
    HOST.addr = ~a;
    HOST.din = ~d;
  endtask : access
endmodule : ocm_host_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the output cell array
// Assumes: no fuses set, so every term is 0 and cells hold host loads
// Notes: reads note their expected byte, a watcher compares on DOUT_OE
`timescale 1ns/100ps
module tb_top;
  import ocm_pkg::*;
  logic MCLK;
  logic RST_N;
  ocm_host_t HOST;
  logic [7:0] DOUT;
  logic DOUT_OE;
  logic LOAD_LEVEL;
  logic EXT_CLK;
  logic [NEXT-1:0] ARR_IN;
  ocm_port_t DIR;
  ocm_port_t IN_CELLS;
  ocm_port_t PIN_OUT;
  ocm_port_t PIN_OE;
  logic [NCS-1:0] CS_OUT;
  logic [2*NCELL-1:0] FEEDBACK;
  ocm_cfg_t [2*NCELL-1:0] cell_cfg;
  logic [7:0] exp_q[$];
  logic [7:0] rnd;
  logic [7:0] v;
  logic oe_prev = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;

  ocm_host_model u_ocm_host_model (.MCLK(MCLK), .HOST(HOST));
  ocm_array u_ocm_array (.MCLK(MCLK), .RST_N(RST_N), .HOST(HOST), .DOUT(DOUT),
    .DOUT_OE(DOUT_OE), .LOAD_LEVEL(LOAD_LEVEL), .EXT_CLK(EXT_CLK), .ARR_IN(ARR_IN),
    .ARR_TRUE('0), .ARR_COMP('0), .CELL_CFG(cell_cfg), .CS_SEL('0), .DIR(DIR),
    .IN_CELLS(IN_CELLS), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .CS_OUT(CS_OUT),
    .FEEDBACK(FEEDBACK));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ocm_host_model.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_ocm_host_model.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // clock, watchdog and read watcher
  // ------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    fail_count++;
    $display("[ERR] run end expected done seen hung");
    report_and_stop();
  end
  // oldest note against each fresh read answer
  always @(negedge MCLK) begin
    oe_prev <= DOUT_OE;
    if (DOUT_OE === 1'b1 && oe_prev !== 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unasked read", 8'h00, 8'hFF);
      end else begin
        check("read data", exp_q.pop_front(), DOUT);
      end
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 2 * NCELL; i++) begin
      cell_cfg[i] = '0;
      cell_cfg[i].use_reg = 1'b1;
      cell_cfg[i].to_pin = 1'b1;
    end
    RST_N = 1'b0;
    LOAD_LEVEL = 1'b0;
    EXT_CLK = 1'b0;
    ARR_IN = '0;
    DIR = '0;
    IN_CELLS = '0;
    rnd = 8'h2F;
    repeat (16) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    rd(OFS_MASK_AB, MASK_RST);
    rd(OFS_MASK_BC, MASK_RST);
    check("pin enable a", 8'hFF, PIN_OE.a);
    check("pin enable b", 8'hFF, PIN_OE.b);
    check("chip selects", 8'h00, {5'h00, CS_OUT});
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      ARR_IN = {rnd[0], {7{rnd}}};
      EXT_CLK = rnd[1];
      wr(OFS_CELL_AB, rnd);
      wr(OFS_CELL_BC, ~rnd);
      rd(OFS_CELL_AB, rnd);
      rd(OFS_CELL_BC, ~rnd);
      check("pins a", rnd, PIN_OUT.a);
      check("pins b", ~rnd, PIN_OUT.b);
      check("feedback ab", rnd, FEEDBACK[7:0]);
      check("feedback bc", ~rnd, FEEDBACK[15:8]);
    end
    $display("test loads done");
    v = rnd;
    wr(OFS_MASK_AB, 8'h0F);
    rd(OFS_MASK_AB, 8'h0F);
    wr(OFS_CELL_AB, ~v);
    rd(OFS_CELL_AB, {~v[7:4], v[3:0]});
    $display("test mask done");
    // level loading shows the new value while the write is still active
    LOAD_LEVEL = 1'b1;
    fork
      wr(OFS_CELL_BC, lfsr(v));
      begin
        repeat (7) @(posedge MCLK);
        #1;
        check("level load", lfsr(v), FEEDBACK[15:8]);
      end
    join
    LOAD_LEVEL = 1'b0;
    rd(OFS_CELL_BC, lfsr(v));
    $display("test level done");
    @(posedge MCLK);
    #1;
    IN_CELLS = '{a: rnd, b: lfsr(rnd), c: ~rnd};
    DIR = '{a: rnd, b: ~rnd, c: 8'h00};
    rd(OFS_IN_A, rnd);
    rd(OFS_IN_B, lfsr(rnd));
    rd(OFS_IN_C, ~rnd);
    u_ocm_host_model.access(1'b0, 8'h7F, 8'h00);
    check("pending reads", 8'h00, 8'(exp_q.size()));
    $display("test readback done");
    // external clock rise captures the empty term sum into bc cell 7
    cell_cfg[15].clk_ext = 1'b1;
    EXT_CLK = 1'b0;
    repeat (4) @(posedge MCLK);
    #1;
    EXT_CLK = 1'b1;
    repeat (6) @(posedge MCLK);
    #1;
    check("ext clock", 8'h00, {7'h00, FEEDBACK[15]});
    $display("test ext clock done");
    report_and_stop();
  end
endmodule : tb_top
